// [inc/usb_otg_pkg.sv]
// Constants, types and helpers for the OTG host session control block.
// What this block does
// - Low-speed bit seven makes transfers signal slowly.
// - NAK answers are retried forever unless disabled.
// - Token write launches the token and data.
// - Completion returns descriptor and raises done flag.
// - Retry disabled: handshake or error into PID.
// - SE0 over 2.5 us flags detach.
// - Clearing VBUS power-on stops powering VBUS.
// - Falling below session end raises session-end flag.
// - Discharge bit drains VBUS through a resistor.
// - VBUS pulse bit; VBUS unwatched while pulsing.
// - Session-valid flag tells B-device to reconnect.
// - Detach and attach flags steer role swap.
// - Role return uses pull-ups, idle and reset.
// - Comparator disable and pin-set select bits.
// - Two-pin comparator inputs decoded to bus level.
// - Three-pin comparator inputs decoded to bus level.
// - OTG enable gives software the pull controls.
package usb_otg_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h00;
	localparam logic [7:0] OFS_OTG_IRQ     = 8'h02;
	localparam logic [7:0] OFS_OTG_CTRL    = 8'h04;
	localparam logic [7:0] OFS_MODULE_CTRL = 8'h06;
	localparam logic [7:0] OFS_EP0_CTRL    = 8'h08;
	localparam logic [7:0] OFS_TARGET_ADDR = 8'h0A;
	localparam logic [7:0] OFS_TOKEN       = 8'h0C;
	localparam logic [7:0] OFS_CONFIG_TWO  = 8'h0E;
	localparam logic [7:0] OFS_BD_STATUS   = 8'h10;
	localparam logic [7:0] OFS_BDT_PAGE    = 8'h12;
	localparam logic [7:0] OFS_FRAME_LOW   = 8'h14;
	localparam logic [7:0] OFS_FRAME_HIGH  = 8'h16;
	localparam logic [7:0] OFS_PWM_RATIO   = 8'h18;
	localparam logic [7:0] OFS_OTG_STATUS  = 8'h1A;

	// Field positions
	localparam int IRQ_DETACH_BIT   = 0;
	localparam int IRQ_DONE_BIT     = 3;
	localparam int IRQ_ATTACH_BIT   = 6;
	localparam int OTGI_SESEND_BIT  = 2;
	localparam int OTGI_SESVLD_BIT  = 3;
	localparam int OC_DP_UP_BIT     = 7;
	localparam int OC_DM_UP_BIT     = 6;
	localparam int OC_DP_DN_BIT     = 5;
	localparam int OC_DM_DN_BIT     = 4;
	localparam int OC_VBUS_ON_BIT   = 3;
	localparam int OC_OTG_EN_BIT    = 2;
	localparam int OC_DISCHARGE_BIT = 0;
	localparam int MC_HOST_EN_BIT   = 3;
	localparam int MC_MOD_EN_BIT    = 0;
	localparam int EP_LOW_SPEED_BIT = 7;
	localparam int EP_RETRY_DIS_BIT = 6;
	localparam int EP_TX_EN_BIT     = 2;
	localparam int C2_PULSE_BIT     = 4;
	localparam int C2_CMP_OFF_BIT   = 1;
	localparam int C2_PIN_SEL_BIT   = 5;
	localparam int BD_OWN_BIT       = 15;
	localparam int BD_PID_LSB       = 10;

	// Reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Handshake codes
	localparam logic [3:0] PID_NAK   = 4'hA;
	localparam logic [3:0] PID_ERROR = 4'hF;

	// Timing
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int DETACH_TIME_NS  = 2500;
	localparam int DETACH_CYCLES   = (DETACH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [9:0] DETACH_COUNT = 10'(DETACH_CYCLES);

	// VBUS levels
	typedef enum logic [1:0] {
		VB_BELOW_END = 2'h0,
		VB_END_TO_VALID = 2'h1,
		VB_VALID_TO_VBUS = 2'h2,
		VB_ABOVE_VBUS = 2'h3
	} vbus_level_t;

	// One-hot transfer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_WAIT  = 3'h2,
		ST_RETRY = 3'h4
	} tx_state_t;

	// Token handed to the line engine
	typedef struct packed {
		logic [3:0] pid;
		logic [3:0] endpoint;
		logic [6:0] address;
		logic       low_speed;
		logic [6:0] byte_count;
	} tx_token_t;

	// Sticky flag update; a set in the clear cycle wins
	function automatic logic [7:0] f_flags(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
		return (cur & ~clr) | set;
	endfunction : f_flags

endpackage : usb_otg_pkg

// [verilog/usb_otg_host_session_control.sv]
// OTG host transfer, session control and VBUS comparator decode logic.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module usb_otg_host_session_control
	import usb_otg_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_resetn,
	// Register port
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [15:0]       i_wr_data,
	input  wire logic              i_wr_en,
	input  wire logic              i_rd_en,
	output logic      [15:0]       o_rd_data,
	// Line engine
	output logic                   o_tx_req,
	output tx_token_t              o_tx_token,
	input  wire logic              i_hs_valid,
	input  wire logic [3:0]        i_hs_pid,
	input  wire logic              i_hs_error,
	// Line state
	input  wire logic              i_line_dp,
	input  wire logic              i_line_dm,
	input  wire logic [10:0]       i_frame_count,
	// VBUS comparators
	input  wire logic              i_int_vbus_valid,
	input  wire logic              i_int_session_valid,
	input  wire logic              i_int_session_end,
	input  wire logic              i_comparator_state_one,
	input  wire logic              i_comparator_state_two,
	input  wire logic              i_vbus_valid_input,
	input  wire logic              i_session_valid_input,
	input  wire logic              i_session_end_input,
	// Analog controls
	output logic                   o_dp_pullup,
	output logic                   o_dm_pullup,
	output logic                   o_dp_pulldown,
	output logic                   o_dm_pulldown,
	output logic                   o_vbus_power_on,
	output logic                   o_vbus_discharge,
	output logic                   o_vbus_pulse,
	output logic                   o_internal_cmp_off
);

	// Narrow buses cannot reach every register
	if (ADDR_W < 5) begin : g_addr_check
		$error("ADDR_W must be at least 5");
	end

	// Reset release through two flops
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Registers
	logic [7:0]  irq_status;
	logic [7:0]  otg_irq;
	logic [7:0]  otg_control_register;
	logic [7:0]  module_ctrl;
	logic [7:0]  endpoint_zero_control;
	logic [7:0]  target_address_register;
	logic [7:0]  token_command_register;
	logic [7:0]  configuration_register_two;
	logic [15:0] bd_status;
	logic [15:0] descriptor_table_page;
	logic [15:0] vbus_boost_pwm_ratio;
	tx_state_t   state;

	// Decoded strobes
	logic [7:0] waddr;
	logic       wr_token;
	logic       token_taken;
	logic       busy;
	assign waddr       = 8'(i_addr);
	assign busy        = (state != ST_IDLE);
	assign wr_token    = i_wr_en && (waddr == OFS_TOKEN);
	assign token_taken = wr_token && !busy && endpoint_zero_control[EP_TX_EN_BIT];

	// Handshake outcome
	logic hs_in_wait;
	logic nak_retry;
	logic finish;
	assign hs_in_wait = (state == ST_WAIT) && i_hs_valid;
	assign nak_retry  = hs_in_wait && !i_hs_error && (i_hs_pid == PID_NAK)
	                    && !endpoint_zero_control[EP_RETRY_DIS_BIT];
	assign finish     = hs_in_wait && !nak_retry;

	// Plain software registers
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			otg_control_register       <= RST_BYTE;
			module_ctrl                <= RST_BYTE;
			endpoint_zero_control      <= RST_BYTE;
			target_address_register    <= RST_BYTE;
			configuration_register_two <= RST_BYTE;
			descriptor_table_page      <= RST_WORD;
			vbus_boost_pwm_ratio       <= RST_WORD;
		end else if (i_wr_en) begin
			case (waddr)
				OFS_OTG_CTRL:    otg_control_register       <= i_wr_data[7:0];
				OFS_MODULE_CTRL: module_ctrl                <= i_wr_data[7:0];
				OFS_EP0_CTRL:    endpoint_zero_control      <= i_wr_data[7:0];
				OFS_TARGET_ADDR: target_address_register    <= i_wr_data[7:0];
				OFS_CONFIG_TWO:  configuration_register_two <= i_wr_data[7:0];
				// Page is word aligned, so bit 0 stays zero
				OFS_BDT_PAGE:    descriptor_table_page      <= {8'h00, i_wr_data[7:1], 1'b0};
				OFS_PWM_RATIO:   vbus_boost_pwm_ratio       <= i_wr_data;
				default: begin
				end
			endcase
		end
	end

	// Token register keeps the last accepted token only
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			token_command_register <= RST_BYTE;
		end else if (token_taken) begin
			token_command_register <= i_wr_data[7:0];
		end
	end

	// Descriptor status: software fills it, hardware returns it
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bd_status <= RST_WORD;
		end else if (finish) begin
			bd_status[BD_OWN_BIT] <= 1'b0;
			if (endpoint_zero_control[EP_RETRY_DIS_BIT]) begin
				bd_status[BD_PID_LSB +: 4] <= i_hs_error ? PID_ERROR : i_hs_pid;
			end
		end else if (i_wr_en && (waddr == OFS_BD_STATUS) && !busy) begin
			// Writes while the engine owns it would corrupt the transfer
			bd_status <= i_wr_data;
		end
	end

	// Transfer engine
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			o_tx_req   <= 1'b0;
			o_tx_token <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (token_taken) begin
						state                 <= ST_WAIT;
						o_tx_req              <= 1'b1;
						o_tx_token.pid        <= i_wr_data[7:4];
						o_tx_token.endpoint   <= i_wr_data[3:0];
						o_tx_token.address    <= target_address_register[6:0];
						o_tx_token.low_speed  <= endpoint_zero_control[EP_LOW_SPEED_BIT];
						o_tx_token.byte_count <= bd_status[6:0];
					end
				end
				ST_WAIT: begin
					if (nak_retry) begin
						state    <= ST_RETRY;
						o_tx_req <= 1'b0;
					end else if (finish) begin
						state    <= ST_IDLE;
						o_tx_req <= 1'b0;
					end
				end
				ST_RETRY: begin
					// One idle cycle lets the engine see a fresh request
					state    <= ST_WAIT;
					o_tx_req <= 1'b1;
				end
				default: begin
					state    <= ST_IDLE;
					o_tx_req <= 1'b0;
				end
			endcase
		end
	end

	// Line state watch for detach and attach
	logic       se0;
	logic       se0_prev;
	logic [9:0] se0_cnt;
	logic       detach_evt;
	assign se0        = !i_line_dp && !i_line_dm;
	assign detach_evt = se0 && (se0_cnt == DETACH_COUNT - 10'h001);
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			se0_cnt  <= 10'h000;
			se0_prev <= 1'b0;
		end else begin
			se0_prev <= se0;
			if (!se0) begin
				se0_cnt <= 10'h000;
			end else if (se0_cnt != DETACH_COUNT) begin
				se0_cnt <= se0_cnt + 10'h001;
			end
		end
	end

	// VBUS level decode from the chosen comparator source
	vbus_level_t level_next;
	vbus_level_t level;
	logic [2:0]  three_pin;
	assign three_pin = {i_vbus_valid_input, i_session_valid_input, i_session_end_input};
	always_comb begin
		level_next = level;
		if (!configuration_register_two[C2_CMP_OFF_BIT]) begin
			if (i_int_vbus_valid) begin
				level_next = VB_ABOVE_VBUS;
			end else if (i_int_session_valid) begin
				level_next = VB_VALID_TO_VBUS;
			end else if (i_int_session_end) begin
				level_next = VB_BELOW_END;
			end else begin
				level_next = VB_END_TO_VALID;
			end
		end else if (!configuration_register_two[C2_PIN_SEL_BIT]) begin
			case ({i_comparator_state_one, i_comparator_state_two})
				2'h0: level_next = VB_BELOW_END;
				2'h2: level_next = VB_END_TO_VALID;
				2'h1: level_next = VB_VALID_TO_VBUS;
				default: level_next = VB_ABOVE_VBUS;
			endcase
		end else begin
			case (three_pin)
				3'h1: level_next = VB_BELOW_END;
				3'h0: level_next = VB_END_TO_VALID;
				3'h2: level_next = VB_VALID_TO_VBUS;
				3'h6: level_next = VB_ABOVE_VBUS;
				// Illegal patterns keep the last good level
				default: level_next = level;
			endcase
		end
	end

	logic sess_valid;
	assign sess_valid = (level == VB_VALID_TO_VBUS) || (level == VB_ABOVE_VBUS);
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= VB_BELOW_END;
		end else begin
			level <= level_next;
		end
	end

	// Flag events
	logic [7:0] irq_set;
	logic [7:0] otg_set;
	logic [7:0] irq_clr;
	logic [7:0] otg_clr;
	logic       pulsing;
	assign pulsing = configuration_register_two[C2_PULSE_BIT];
	always_comb begin
		irq_set                 = 8'h00;
		otg_set                 = 8'h00;
		irq_set[IRQ_DETACH_BIT] = detach_evt;
		irq_set[IRQ_DONE_BIT]   = finish;
		irq_set[IRQ_ATTACH_BIT] = se0_prev && !se0;
		// VBUS is ignored while software pulses it
		otg_set[OTGI_SESEND_BIT] = !pulsing && (level_next == VB_BELOW_END)
		                           && (level != VB_BELOW_END);
		otg_set[OTGI_SESVLD_BIT] = !pulsing && !sess_valid
		                           && (level_next inside {VB_VALID_TO_VBUS, VB_ABOVE_VBUS});
	end
	assign irq_clr = (i_wr_en && (waddr == OFS_IRQ_STATUS)) ? i_wr_data[7:0] : 8'h00;
	assign otg_clr = (i_wr_en && (waddr == OFS_OTG_IRQ)) ? i_wr_data[7:0] : 8'h00;

	// Write-one-to-clear flags
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= RST_BYTE;
			otg_irq    <= RST_BYTE;
		end else begin
			irq_status <= f_flags(irq_status, irq_set, irq_clr);
			otg_irq    <= f_flags(otg_irq, otg_set, otg_clr);
		end
	end

	// Pull resistor and VBUS drives
	logic host_en;
	logic mod_en;
	assign host_en = module_ctrl[MC_HOST_EN_BIT];
	assign mod_en  = module_ctrl[MC_MOD_EN_BIT];
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_dp_pullup   <= 1'b0;
			o_dm_pullup   <= 1'b0;
			o_dp_pulldown <= 1'b0;
			o_dm_pulldown <= 1'b0;
		end else if (otg_control_register[OC_OTG_EN_BIT]) begin
			o_dp_pullup   <= otg_control_register[OC_DP_UP_BIT];
			o_dm_pullup   <= otg_control_register[OC_DM_UP_BIT];
			o_dp_pulldown <= otg_control_register[OC_DP_DN_BIT];
			o_dm_pulldown <= otg_control_register[OC_DM_DN_BIT];
		end else begin
			// Hardware picks host pull-downs or a full-speed pull-up
			o_dp_pullup   <= mod_en && !host_en;
			o_dm_pullup   <= 1'b0;
			o_dp_pulldown <= host_en;
			o_dm_pulldown <= host_en;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_vbus_power_on    <= 1'b0;
			o_vbus_discharge   <= 1'b0;
			o_vbus_pulse       <= 1'b0;
			o_internal_cmp_off <= 1'b0;
		end else begin
			o_vbus_power_on    <= otg_control_register[OC_VBUS_ON_BIT];
			o_vbus_discharge   <= otg_control_register[OC_DISCHARGE_BIT];
			o_vbus_pulse       <= pulsing;
			o_internal_cmp_off <= configuration_register_two[C2_CMP_OFF_BIT];
		end
	end

	// Read data, valid only in the cycle after the strobe
	logic [15:0] rd_mux;
	always_comb begin
		case (waddr)
			OFS_IRQ_STATUS:  rd_mux = {8'h00, irq_status};
			OFS_OTG_IRQ:     rd_mux = {8'h00, otg_irq};
			OFS_OTG_CTRL:    rd_mux = {8'h00, otg_control_register};
			OFS_MODULE_CTRL: rd_mux = {8'h00, module_ctrl};
			OFS_EP0_CTRL:    rd_mux = {8'h00, endpoint_zero_control};
			OFS_TARGET_ADDR: rd_mux = {8'h00, target_address_register};
			OFS_TOKEN:       rd_mux = {8'h00, token_command_register};
			OFS_CONFIG_TWO:  rd_mux = {8'h00, configuration_register_two};
			OFS_BD_STATUS:   rd_mux = bd_status;
			OFS_BDT_PAGE:    rd_mux = descriptor_table_page;
			OFS_FRAME_LOW:   rd_mux = {8'h00, i_frame_count[7:0]};
			OFS_FRAME_HIGH:  rd_mux = {13'h0000, i_frame_count[10:8]};
			OFS_PWM_RATIO:   rd_mux = vbus_boost_pwm_ratio;
			OFS_OTG_STATUS:  rd_mux = {12'h000, sess_valid, level == VB_BELOW_END, 1'b0, level == VB_ABOVE_VBUS};
			default:         rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rd_data <= 16'h0000;
		end else begin
			o_rd_data <= i_rd_en ? rd_mux : 16'h0000;
		end
	end

	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_nak_seen;
		nak_retry;
	endsequence
	sequence s_drop_then_reissue;
		!o_tx_req ##1 o_tx_req;
	endsequence

	property p_token_start;
		token_taken |=> o_tx_req && (o_tx_token.address == $past(target_address_register[6:0]));
	endproperty
	a_token_start: assert property (p_token_start) else $error("token write did not start transfer");

	property p_busy_ignore;
		wr_token && busy |=> $stable(o_tx_token) && $stable(token_command_register);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("token accepted while busy");

	property p_retry;
		s_nak_seen |=> s_drop_then_reissue;
	endproperty
	a_retry: assert property (p_retry) else $error("NAK was not retried");

	property p_done;
		finish |=> irq_status[IRQ_DONE_BIT] && !bd_status[BD_OWN_BIT] && !o_tx_req;
	endproperty
	a_done: assert property (p_done) else $error("completion not reported");

	property p_pid;
		finish && endpoint_zero_control[EP_RETRY_DIS_BIT]
		|=> bd_status[BD_PID_LSB +: 4] == ($past(i_hs_error) ? PID_ERROR : $past(i_hs_pid));
	endproperty
	a_pid: assert property (p_pid) else $error("handshake not stored");

	property p_detach;
		!se0 ##1 se0 [*8] |-> !irq_status[IRQ_DETACH_BIT] || $past(irq_status[IRQ_DETACH_BIT], 8);
	endproperty
	a_detach: assert property (p_detach) else $error("detach flagged too early");

	property p_detach_set;
		detach_evt |=> irq_status[IRQ_DETACH_BIT];
	endproperty
	a_detach_set: assert property (p_detach_set) else $error("detach not flagged");

	property p_vbus_power;
		##1 o_vbus_power_on == $past(otg_control_register[OC_VBUS_ON_BIT]);
	endproperty
	a_vbus_power: assert property (p_vbus_power) else $error("VBUS power not following control");

	property p_discharge;
		$rose(otg_control_register[OC_DISCHARGE_BIT]) |=> o_vbus_discharge;
	endproperty
	a_discharge: assert property (p_discharge) else $error("discharge not applied");

	property p_low_speed;
		$rose(o_tx_req) && $past(state == ST_IDLE)
		|-> o_tx_token.low_speed == $past(endpoint_zero_control[EP_LOW_SPEED_BIT]);
	endproperty
	a_low_speed: assert property (p_low_speed) else $error("speed not carried");

	property p_pulls;
		!otg_control_register[OC_OTG_EN_BIT] && host_en |=> o_dp_pulldown && o_dm_pulldown && !o_dp_pullup;
	endproperty
	a_pulls: assert property (p_pulls) else $error("host pulls wrong");

	property p_sesend;
		otg_set[OTGI_SESEND_BIT] |=> otg_irq[OTGI_SESEND_BIT] && (level == VB_BELOW_END);
	endproperty
	a_sesend: assert property (p_sesend) else $error("session end not flagged");

endmodule : usb_otg_host_session_control

// [test/usb_target_model.sv]
// Behavioural far-side target that answers each host transaction with a handshake.
`timescale 1ns/1ps
module usb_target_model
	import usb_otg_pkg::*;
(
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_resetn,
	// Scenario control
	input  wire logic       i_restart,
	input  wire logic [3:0] i_nak_count,
	input  wire logic [3:0] i_final_pid,
	input  wire logic       i_final_error,
	input  wire logic [3:0] i_delay,
	// Transaction link
	input  wire logic       i_tx_req,
	output logic            o_hs_valid,
	output logic [3:0]      o_hs_pid,
	output logic            o_hs_error,
	output logic [7:0]      o_answers
);
	logic [3:0] wait_cnt;
	logic       answered;

	// One answer per request after a chosen delay: NAKs first, then the final handshake
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hs_valid <= 1'b0;
			o_hs_pid   <= 4'h0;
			o_hs_error <= 1'b0;
			o_answers  <= 8'h00;
			wait_cnt   <= 4'h0;
			answered   <= 1'b0;
		end else begin
			o_hs_valid <= 1'b0;
			// Idle lines toggle so a stale handshake never reads as a fresh one
			o_hs_pid   <= ~o_hs_pid;
			o_hs_error <= ~o_hs_error;
			if (i_restart) begin
				o_answers <= 8'h00;
			end
			if (!i_tx_req) begin
				wait_cnt <= 4'h0;
				answered <= 1'b0;
			end else if (!answered && wait_cnt == i_delay) begin
				o_hs_valid <= 1'b1;
				answered   <= 1'b1;
				o_answers  <= o_answers + 8'h01;
				o_hs_pid   <= (o_answers < {4'h0, i_nak_count}) ? PID_NAK : i_final_pid;
				o_hs_error <= (o_answers >= {4'h0, i_nak_count}) & i_final_error;
			end else if (!answered) begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule : usb_target_model

// [test/usb_otg_host_session_control_test.sv]
// Self-checking bench for the OTG host session control block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module usb_otg_host_session_control_test
	import usb_otg_pkg::*;
;
	logic        ref_clk, resetn, wr_en, rd_en, hs_valid, hs_error, tx_req, dp, dm;
	logic        st1, st2, vv, sv, se, restart, fin_err, iv, isv, ie;
	logic [7:0]  addr, answers;
	logic [15:0] wr_data, rd_data;
	logic [3:0]  hs_pid, naks, fin_pid;
	wire  [7:0]  outs;
	tx_token_t   tx_token;
	int          mismatches, total_checks;

	usb_otg_host_session_control i_usb_otg_host_session_control (.i_ref_clk(ref_clk), .i_resetn(resetn),
		.i_addr(addr), .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
		.o_tx_req(tx_req), .o_tx_token(tx_token), .i_hs_valid(hs_valid), .i_hs_pid(hs_pid),
		.i_hs_error(hs_error), .i_line_dp(dp), .i_line_dm(dm), .i_frame_count(11'h5A3),
		.i_int_vbus_valid(iv), .i_int_session_valid(isv), .i_int_session_end(ie),
		.i_comparator_state_one(st1), .i_comparator_state_two(st2), .i_vbus_valid_input(vv),
		.i_session_valid_input(sv), .i_session_end_input(se), .o_dp_pullup(outs[7]), .o_dm_pullup(outs[6]),
		.o_dp_pulldown(outs[5]), .o_dm_pulldown(outs[4]), .o_vbus_power_on(outs[3]),
		.o_vbus_discharge(outs[2]), .o_vbus_pulse(outs[1]), .o_internal_cmp_off(outs[0]));
	usb_target_model i_usb_target_model (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_restart(restart),
		.i_nak_count(naks), .i_final_pid(fin_pid), .i_final_error(fin_err), .i_delay(4'h6),
		.i_tx_req(tx_req), .o_hs_valid(hs_valid), .o_hs_pid(hs_pid), .o_hs_error(hs_error), .o_answers(answers));

	// Clock at 200 MHz
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		if (mismatches == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out

	// One-cycle write strobe, changed just after the edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
		// Return on an edge so the next stimulus lands on it
		@(posedge ref_clk);
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [15:0] ex);
		logic [15:0] d;
		rd(a, d);
		`CHK("register", ex, d)
	endtask : rchk

	task automatic settle(input logic [7:0] ex);
		repeat (3) @(posedge ref_clk);
		#1 `CHK("controls", ex, outs)
		@(posedge ref_clk);
	endtask : settle

	// Bulk OUT transfer against the target; also tries a token write while busy
	task automatic xfer(input logic [7:0] ep, input logic [3:0] nk, pid, input logic er, input logic [7:0] n,
		input logic [15:0] bd);
		logic [15:0] d;
		naks <= nk;
		fin_pid <= pid;
		fin_err <= er;
		restart <= 1'b1;
		@(posedge ref_clk);
		restart <= 1'b0;
		wr(OFS_EP0_CTRL, {8'h00, ep});
		wr(OFS_TARGET_ADDR, 16'h0055);
		wr(OFS_BD_STATUS, 16'h8040);
		wr(OFS_TOKEN, 16'h0010);
		@(posedge ref_clk);
		#1 `CHK("tx_req", 1'b1, tx_req)
		`CHK("tx_token", {4'h1, 4'h0, 7'h55, ep[7], 7'h40}, tx_token)
		wr(OFS_TOKEN, 16'h0019);
		for (int i = 0; i < 300; i++) begin
			rd(OFS_IRQ_STATUS, d);
			if (d[IRQ_DONE_BIT] === 1'b1) break;
		end
		`CHK("done_flag", 1'b1, d[IRQ_DONE_BIT])
		`CHK("answers", n, answers)
		rchk(OFS_BD_STATUS, bd);
		rchk(OFS_TOKEN, 16'h0010);
		wr(OFS_IRQ_STATUS, 16'h0008);
	endtask : xfer

	task automatic detach_attach();
		dp <= 1'b0;
		dm <= 1'b0;
		repeat (2500 / 5 - 3) @(posedge ref_clk);
		rchk(OFS_IRQ_STATUS, 16'h0000);
		repeat (12) @(posedge ref_clk);
		rchk(OFS_IRQ_STATUS, 16'h0001);
		dp <= 1'b1;
		rchk(OFS_IRQ_STATUS, 16'h0041);
		wr(OFS_IRQ_STATUS, 16'h00FF);
		rchk(OFS_IRQ_STATUS, 16'h0000);
	endtask : detach_attach

	task automatic pulls_and_vbus();
		wr(OFS_MODULE_CTRL, 16'h0009);
		settle(8'h30);
		wr(OFS_MODULE_CTRL, 16'h0001);
		settle(8'h80);
		wr(OFS_OTG_CTRL, 16'h00C4);
		settle(8'hC0);
		wr(OFS_OTG_CTRL, 16'h0004);
		settle(8'h00);
		wr(OFS_OTG_CTRL, 16'h008D);
		settle(8'h8C);
		wr(OFS_OTG_CTRL, 16'h0084);
		settle(8'h80);
	endtask : pulls_and_vbus

	// External comparator decode; level changes raise session flags unless pulsing
	task automatic comparators();
		logic [7:0] two [4] = '{8'h04, 8'h00, 8'h08, 8'h09};
		logic [2:0] three [4] = '{3'b001, 3'b000, 3'b010, 3'b110};
		// Internal comparators: session valid outranks session end
		{iv, isv, ie} <= 3'b011;
		rchk(OFS_OTG_STATUS, 16'h0008);
		wr(OFS_CONFIG_TWO, 16'h0002);
		for (int i = 0; i < 5; i++) begin
			{st1, st2} <= (i == 4) ? 2'b00 : {i[0], i[1]};
			rchk(OFS_OTG_STATUS, {8'h00, two[i % 4]});
		end
		rchk(OFS_OTG_IRQ, 16'h000C);
		wr(OFS_OTG_IRQ, 16'h000C);
		wr(OFS_CONFIG_TWO, 16'h0032);
		settle(8'h83);
		for (int i = 0; i < 4; i++) begin
			{vv, sv, se} <= three[i];
			rchk(OFS_OTG_STATUS, {8'h00, two[i]});
		end
		rchk(OFS_OTG_IRQ, 16'h0000);
	endtask : comparators

	task automatic plain_regs();
		rchk(OFS_IRQ_STATUS, RST_WORD);
		rchk(OFS_OTG_CTRL, RST_WORD);
		rchk(OFS_BDT_PAGE, RST_WORD);
		rchk(8'h1C, 16'h0000);
		wr(OFS_BDT_PAGE, 16'hFFFF);
		rchk(OFS_BDT_PAGE, 16'h00FE);
		wr(OFS_PWM_RATIO, 16'hBEEF);
		rchk(OFS_PWM_RATIO, 16'hBEEF);
		wr(OFS_FRAME_LOW, 16'h0011);
		rchk(OFS_FRAME_LOW, 16'h00A3);
		rchk(OFS_FRAME_HIGH, 16'h0005);
	endtask : plain_regs

	// Main sequence
	initial begin
		{resetn, wr_en, rd_en, restart, fin_err, st1, st2, vv, sv, se, dm, iv, isv, ie} = '0;
		{addr, wr_data, naks, fin_pid} = '0;
		dp = 1'b1;
		mismatches = 0;
		total_checks = 0;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		plain_regs();
		xfer(8'h1D, 4'h3, 4'h2, 1'b0, 8'h04, 16'h0040);
		xfer(8'hDD, 4'h0, 4'hA, 1'b0, 8'h01, 16'h2840);
		xfer(8'h5D, 4'h0, 4'hE, 1'b0, 8'h01, 16'h3840);
		xfer(8'h5D, 4'h0, 4'h2, 1'b0, 8'h01, 16'h0840);
		xfer(8'h5D, 4'h0, 4'h2, 1'b1, 8'h01, 16'h3C40);
		detach_attach();
		pulls_and_vbus();
		comparators();
		close_out();
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		close_out();
	end
endmodule : usb_otg_host_session_control_test
